// ### fesm_map.svh
// offsets, encodings and field positions for the flash erase, security and margin sequencer
`ifndef FESM_MAP_SVH
`define FESM_MAP_SVH

// command codes, carried in the upper byte of word 0
`define FESM_CMD_ERASE_BLOCK  8'h09
`define FESM_CMD_ERASE_SECTOR 8'h0A
`define FESM_CMD_UNSECURE     8'h0B
`define FESM_CMD_VERIFY_KEY   8'h0C
`define FESM_CMD_SET_MARGIN   8'h0D

// field positions inside word 0
`define FESM_CODE_HI 15
`define FESM_CODE_LO 8
`define FESM_BLK_HI  1
`define FESM_BLK_LO  0

// last command word index expected at launch
`define FESM_LAST_IDX_ERASE_BLOCK  3'h1
`define FESM_LAST_IDX_ERASE_SECTOR 3'h1
`define FESM_LAST_IDX_UNSECURE     3'h0
`define FESM_LAST_IDX_VERIFY_KEY   3'h4
`define FESM_LAST_IDX_SET_MARGIN   3'h1

// block select codes of global address bits 17:16
`define FESM_BLK_PFLASH 2'h3
`define FESM_BLK_DFLASH 2'h0

// back-door key enable field value that allows the key command
`define FESM_BACKDOOR_KEY_ENABLE_FIELD_ON 2'h2

// margin setting words
`define FESM_MARGIN_NORMAL 16'h0000
`define FESM_MARGIN_LEVEL1 16'h0001
`define FESM_MARGIN_LEVEL0 16'h0002

// bit positions in the command availability mask
`define FESM_AVAIL_ERASE_BLOCK  0
`define FESM_AVAIL_ERASE_SECTOR 1
`define FESM_AVAIL_UNSECURE     2
`define FESM_AVAIL_VERIFY_KEY   3
`define FESM_AVAIL_SET_MARGIN   4

// reset values
`define FESM_RST_IDX 3'h0
`define FESM_RST_WORD 16'h0000

`endif

// ### fesm_pkg.sv
// types shared by the flash erase, security and margin sequencer
package fesm_pkg;

  typedef enum logic [1:0] {
    FESM_ST_IDLE  = 2'b00,
    FESM_ST_CHECK = 2'b01,
    FESM_ST_ERASE = 2'b10
  } fesm_state_t;

  typedef enum logic [1:0] {
    FESM_ER_BLOCK  = 2'b00,
    FESM_ER_SECTOR = 2'b01,
    FESM_ER_ALL    = 2'b10
  } fesm_erase_kind_t;

  typedef enum logic [1:0] {
    FESM_MG_NORMAL     = 2'b00,
    FESM_MG_ERASED     = 2'b01,
    FESM_MG_PROGRAMMED = 2'b10
  } fesm_margin_t;

endpackage

// ### fesm_key_cmp.sv
// back-door key comparator: four supplied words against the stored key
module fesm_key_cmp #(
  parameter int WORDS = 4
) (
  input  wire logic [15:0]         key_word [WORDS],
  input  wire logic [16*WORDS-1:0] stored_key,
  output logic                     key_match
);
  import fesm_pkg::*;

  logic [WORDS-1:0] word_eq;

  // key 0 sits in the low word of the stored key, the lowest address
  genvar gi;
  generate
    for (gi = 0; gi < WORDS; gi++)
    begin : g_word
      assign word_eq[gi] = (key_word[gi] == stored_key[16*gi +: 16]);
    end
  endgenerate

  assign key_match = &word_eq;

endmodule

// ### fesm_seq.sv
// command sequencer for block erase, sector erase, unsecure, back-door key and user margin
`include "fesm_map.svh"

// What this block does
// - erase-block is 0x09, block bits, address word
// - erase block, verify, then set complete flag
// - erase-block access error: index, block, alignment
// - unavailable command in mode sets access error
// - protected area in block sets protection flag
// - verify errors set verify and uncorrectable flags
// - sector-erase is 0x0A, block bits, address
// - erase sector, verify, then set complete
// - sector misaligned is access error; protected violation
// - unsecure 0x0B erases all, releases on pass
// - unsecure verify fail keeps security, sets flag
// - any protected area blocks unsecure
// - key command 0x0C, last index four
// - key enable field must be binary 10
// - full key match releases security, completes
// - mismatch locks key command until reset
// - margin command 0x0D sets future reads
// - data margin data only; program margins both
// - margin word 0 normal, 1 level1, 2 level0
// - level1 toward erased, level0 toward programmed
// - margin access error: index, block, setting
module fesm_seq (
  input  wire logic                    clock,
  input  wire logic                    reset_n,
  input  wire logic                    cmd_word_wr,
  input  wire logic [2:0]              command_word_index,
  input  wire logic [15:0]             cmd_word_wr_data,
  input  wire logic                    cmd_launch,
  input  wire logic                    access_error_clear,
  input  wire logic                    protection_violation_clear,
  input  wire logic [4:0]              cmd_enable_mask,
  input  wire logic [1:0]              backdoor_key_enable_field,
  input  wire logic [63:0]             stored_key_words,
  input  wire logic                    target_block_protected,
  input  wire logic                    target_sector_protected,
  input  wire logic                    pflash_protected_any,
  input  wire logic                    dflash_protected_any,
  input  wire logic                    erase_done,
  input  wire logic                    erase_verify_error,
  input  wire logic                    erase_verify_uncorrectable,
  output logic                         command_complete_flag,
  output logic                         access_error_flag,
  output logic                         protection_violation_flag,
  output logic                         verify_error_flag,
  output logic                         verify_uncorrectable_flag,
  output logic                         security_released,
  output logic                         backdoor_locked,
  output logic                         erase_req,
  output fesm_pkg::fesm_erase_kind_t   erase_kind,
  output logic [1:0]                   erase_block,
  output logic [15:0]                  erase_addr,
  output fesm_pkg::fesm_margin_t       pflash_read_margin,
  output fesm_pkg::fesm_margin_t       dflash_read_margin
);
  import fesm_pkg::*;

  // ==========================================================
  // command object storage
  // ==========================================================
  logic [15:0]      words_q [5];
  logic [2:0]       last_idx_q;
  fesm_state_t      state_q;
  logic             command_complete_flag_q;
  logic             access_error_flag_q;
  logic             protection_violation_flag_q;
  logic             mg1_q;
  logic             mg0_q;
  logic             released_q;
  logic             locked_q;
  logic             ereq_q;
  fesm_erase_kind_t ekind_q;
  logic [1:0]       eblk_q;
  logic [15:0]      eaddr_q;
  fesm_margin_t     pmargin_q;
  fesm_margin_t     dmargin_q;

  // writes while a command runs are dropped; software must not issue them
  wire word_we = cmd_word_wr & command_complete_flag_q & (command_word_index <= 3'h5 - 3'h1);

  genvar gw;
  generate
    for (gw = 0; gw < 5; gw++)
    begin : g_words
      always_ff @(posedge clock or negedge reset_n)
      begin
        if (!reset_n)
          words_q[gw] <= `FESM_RST_WORD;
        else if (word_we && command_word_index == 3'(gw))
          words_q[gw] <= cmd_word_wr_data;
      end
    end
  endgenerate

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      last_idx_q <= `FESM_RST_IDX;
    else if (word_we)
      last_idx_q <= command_word_index;
  end

  // ==========================================================
  // command decode and checks
  // ==========================================================
  wire [7:0]  code      = words_q[0][`FESM_CODE_HI:`FESM_CODE_LO];
  wire [1:0]  blk       = words_q[0][`FESM_BLK_HI:`FESM_BLK_LO];
  wire [15:0] setting   = words_q[1];
  wire is_blk_erase     = (code == `FESM_CMD_ERASE_BLOCK);
  wire is_sec_erase     = (code == `FESM_CMD_ERASE_SECTOR);
  wire is_unsecure      = (code == `FESM_CMD_UNSECURE);
  wire is_key           = (code == `FESM_CMD_VERIFY_KEY);
  wire is_margin        = (code == `FESM_CMD_SET_MARGIN);
  wire is_known         = is_blk_erase | is_sec_erase | is_unsecure | is_key | is_margin;
  wire blk_is_p         = (blk == `FESM_BLK_PFLASH);
  wire blk_is_d         = (blk == `FESM_BLK_DFLASH);
  wire blk_valid        = blk_is_p | blk_is_d;

  // availability in the current operating mode, one mask bit per command
  wire avail = (is_blk_erase & cmd_enable_mask[`FESM_AVAIL_ERASE_BLOCK])
             | (is_sec_erase & cmd_enable_mask[`FESM_AVAIL_ERASE_SECTOR])
             | (is_unsecure  & cmd_enable_mask[`FESM_AVAIL_UNSECURE])
             | (is_key       & cmd_enable_mask[`FESM_AVAIL_VERIFY_KEY])
             | (is_margin    & cmd_enable_mask[`FESM_AVAIL_SET_MARGIN]);

  // phrase alignment on program array, word alignment on data array
  wire blk_misalign = blk_is_p ? (setting[2:0] != 3'h0) : setting[0];
  wire sec_misalign = (setting[2:0] != 3'h0);

  wire err_blk = is_blk_erase & ((last_idx_q != `FESM_LAST_IDX_ERASE_BLOCK) | ~blk_valid | blk_misalign);
  wire err_sec = is_sec_erase & ((last_idx_q != `FESM_LAST_IDX_ERASE_SECTOR) | ~blk_is_p | sec_misalign);
  wire err_uns = is_unsecure & (last_idx_q != `FESM_LAST_IDX_UNSECURE);
  wire backdoor_key_enable_field_ok = (backdoor_key_enable_field == `FESM_BACKDOOR_KEY_ENABLE_FIELD_ON);
  wire err_key = is_key & ((last_idx_q != `FESM_LAST_IDX_VERIFY_KEY) | ~backdoor_key_enable_field_ok | locked_q);
  wire margin_ok = (setting == `FESM_MARGIN_NORMAL) | (setting == `FESM_MARGIN_LEVEL1)
                 | (setting == `FESM_MARGIN_LEVEL0);
  wire err_mar = is_margin & ((last_idx_q != `FESM_LAST_IDX_SET_MARGIN) | ~blk_valid | ~margin_ok);

  // unknown codes are refused as an access error too
  wire acc_err = ~is_known | ~avail | err_blk | err_sec | err_uns | err_key | err_mar;

  wire prot_err = (is_blk_erase & target_block_protected)
                | (is_sec_erase & target_sector_protected)
                | (is_unsecure & (pflash_protected_any | dflash_protected_any));

  // key words live at indices one through four
  logic        key_match;
  logic [15:0] key_word [4];
  assign key_word[0] = words_q[1];
  assign key_word[1] = words_q[2];
  assign key_word[2] = words_q[3];
  assign key_word[3] = words_q[4];

  fesm_key_cmp #(
    .WORDS      (4)
  ) u_key_cmp (
    .key_word   (key_word),
    .stored_key (stored_key_words),
    .key_match  (key_match)
  );

  // margin word to read level: level1 toward erased, level0 toward programmed
  wire fesm_margin_t new_margin = (setting == `FESM_MARGIN_LEVEL1) ? FESM_MG_ERASED :
                                  (setting == `FESM_MARGIN_LEVEL0) ? FESM_MG_PROGRAMMED :
                                  FESM_MG_NORMAL;

  // ==========================================================
  // sequencer
  // ==========================================================
  // a launch while an error flag stands is ignored, as the flags must be cleared first
  wire launch   = cmd_launch & command_complete_flag_q & ~access_error_flag_q & ~protection_violation_flag_q;
  wire in_check = (state_q == FESM_ST_CHECK);
  wire go_ok    = in_check & ~acc_err & ~prot_err;
  wire start_er = go_ok & (is_blk_erase | is_sec_erase | is_unsecure);
  wire key_go   = go_ok & is_key;
  wire mar_go   = go_ok & is_margin;
  wire er_fin   = (state_q == FESM_ST_ERASE) & erase_done;
  wire ver_bad  = erase_verify_error | erase_verify_uncorrectable;

  // hardware sets win over software clears in the same cycle
  wire acc_set = (in_check & acc_err) | (key_go & ~key_match);
  wire fpv_set = in_check & ~acc_err & prot_err;
  wire acc_d   = acc_set | (access_error_flag_q & ~access_error_clear);
  wire fpv_d   = fpv_set | (protection_violation_flag_q & ~protection_violation_clear);

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      state_q <= FESM_ST_IDLE;
    else
      unique case (state_q)
        FESM_ST_IDLE:  state_q <= launch ? FESM_ST_CHECK : FESM_ST_IDLE;
        FESM_ST_CHECK: state_q <= start_er ? FESM_ST_ERASE : FESM_ST_IDLE;
        FESM_ST_ERASE: state_q <= erase_done ? FESM_ST_IDLE : FESM_ST_ERASE;
        default:       state_q <= FESM_ST_IDLE;
      endcase
  end

  // complete flag drops on launch, rises when the operation ends
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      command_complete_flag_q <= 1'b1;
    else if (launch)
      command_complete_flag_q <= 1'b0;
    else if ((in_check & ~start_er) | er_fin)
      command_complete_flag_q <= 1'b1;
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      access_error_flag_q <= 1'b0;
      protection_violation_flag_q <= 1'b0;
    end
    else
    begin
      access_error_flag_q <= acc_d;
      protection_violation_flag_q <= fpv_d;
    end
  end

  // verify flags clear on launch and report the post-erase verify
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mg1_q <= 1'b0;
      mg0_q <= 1'b0;
    end
    else if (launch)
    begin
      mg1_q <= 1'b0;
      mg0_q <= 1'b0;
    end
    else if (er_fin)
    begin
      mg1_q <= erase_verify_error;
      mg0_q <= erase_verify_uncorrectable;
    end
  end

  // security release and key lockout; only reset ends the lockout
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      released_q <= 1'b0;
      locked_q   <= 1'b0;
    end
    else
    begin
      if ((er_fin & (ekind_q == FESM_ER_ALL) & ~ver_bad) | (key_go & key_match))
        released_q <= 1'b1;
      if (key_go & ~key_match)
        locked_q <= 1'b1;
    end
  end

  // erase target latched at launch so protection lookup sees it during the check
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      eblk_q  <= 2'h0;
      eaddr_q <= 16'h0000;
      ekind_q <= FESM_ER_BLOCK;
    end
    else if (launch)
    begin
      eblk_q  <= blk;
      eaddr_q <= setting;
      ekind_q <= is_unsecure ? FESM_ER_ALL : (is_sec_erase ? FESM_ER_SECTOR : FESM_ER_BLOCK);
    end
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      ereq_q <= 1'b0;
    else if (start_er)
      ereq_q <= 1'b1;
    else if (er_fin)
      ereq_q <= 1'b0;
  end

  // program array margin applies to both arrays, data array margin to data only
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pmargin_q <= FESM_MG_NORMAL;
      dmargin_q <= FESM_MG_NORMAL;
    end
    else if (mar_go)
    begin
      dmargin_q <= new_margin;
      if (blk_is_p)
        pmargin_q <= new_margin;
    end
  end

  assign command_complete_flag     = command_complete_flag_q;
  assign access_error_flag         = access_error_flag_q;
  assign protection_violation_flag = protection_violation_flag_q;
  assign verify_error_flag         = mg1_q;
  assign verify_uncorrectable_flag = mg0_q;
  assign security_released         = released_q;
  assign backdoor_locked           = locked_q;
  assign erase_req                 = ereq_q;
  assign erase_kind                = ekind_q;
  assign erase_block               = eblk_q;
  assign erase_addr                = eaddr_q;
  assign pflash_read_margin        = pmargin_q;
  assign dflash_read_margin        = dmargin_q;

  // ==========================================================
  // assertions
  // ==========================================================
  a_erase_holds_command_complete_flag: assert property (@(posedge clock) disable iff (!reset_n)
    ereq_q |-> !command_complete_flag_q) else $error("complete flag high during erase");
  a_erase_done_command_complete_flag: assert property (@(posedge clock) disable iff (!reset_n)
    (state_q == FESM_ST_ERASE && erase_done) |=> command_complete_flag_q && !ereq_q) else $error("erase end did not complete");
  a_blk_index_err: assert property (@(posedge clock) disable iff (!reset_n)
    (in_check && is_blk_erase && last_idx_q != 3'h1) |=> access_error_flag_q && command_complete_flag_q && !ereq_q)
    else $error("bad erase index not refused");
  a_avail_err: assert property (@(posedge clock) disable iff (!reset_n)
    (in_check && !avail) |=> access_error_flag_q ##1 $stable(released_q)) else $error("unavailable command ran");
  a_blk_protect: assert property (@(posedge clock) disable iff (!reset_n)
    (in_check && is_blk_erase && !acc_err && target_block_protected) |=> protection_violation_flag_q && !ereq_q)
    else $error("protected block erased");
  a_verify_flags: assert property (@(posedge clock) disable iff (!reset_n)
    (state_q == FESM_ST_ERASE && erase_done) |=> mg1_q == $past(erase_verify_error) && mg0_q == $past(erase_verify_uncorrectable))
    else $error("verify flags wrong");
  a_sec_align: assert property (@(posedge clock) disable iff (!reset_n)
    (in_check && is_sec_erase && setting[2:0] != 3'h0) |=> access_error_flag_q) else $error("misaligned sector accepted");
  a_unsec_fail: assert property (@(posedge clock) disable iff (!reset_n)
    (state_q == FESM_ST_ERASE && erase_done && ekind_q == FESM_ER_ALL && erase_verify_error) |=> $stable(released_q))
    else $error("security released after failed verify");
  a_backdoor_key_enable_field_check: assert property (@(posedge clock) disable iff (!reset_n)
    (in_check && is_key && backdoor_key_enable_field != 2'h2) |=> access_error_flag_q && $stable(locked_q))
    else $error("disabled key command compared");
  a_key_lockout: assert property (@(posedge clock) disable iff (!reset_n)
    (in_check && is_key && locked_q) |=> access_error_flag_q && $stable(released_q)) else $error("locked key command ran");
  a_dmargin_only: assert property (@(posedge clock) disable iff (!reset_n)
    (mar_go && blk_is_d) |=> $stable(pmargin_q) && dmargin_q == $past(new_margin))
    else $error("data margin touched program reads");

endmodule

// ### fesm_array_model.sv
// behavioural model of the program and data flash arrays behind the sequencer
module fesm_array_model (
  input  wire logic       clock,
  input  wire logic       reset_n,
  input  wire logic       erase_req,
  input  wire logic [1:0] erase_block,
  input  wire logic [7:0] delay,
  input  wire logic       fail_verify,
  input  wire logic       fail_ecc,
  input  wire logic [3:0] prot_blk,
  input  wire logic       prot_sector,
  output logic            erase_done,
  output logic            erase_verify_error,
  output logic            erase_verify_uncorrectable,
  output logic            target_block_protected,
  output logic            target_sector_protected,
  output logic            pflash_protected_any,
  output logic            dflash_protected_any
);
  logic [7:0] cnt_q;
  logic       tog_q;

  // ==========================================
  // protection map, one bit per block code
  assign target_block_protected  = prot_blk[erase_block];
  assign target_sector_protected = prot_sector;
  assign pflash_protected_any    = prot_blk[3];
  assign dflash_protected_any    = prot_blk[0];
  // verify results only mean something with done; otherwise they wander
  assign erase_verify_error         = erase_done ? fail_verify : tog_q;
  assign erase_verify_uncorrectable = erase_done ? fail_ecc : ~tog_q;

  // ==========================================
  // erase timer: one done pulse per request, after the set delay
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt_q      <= 8'h00;
      tog_q      <= 1'b0;
      erase_done <= 1'b0;
    end
    else
    begin
      tog_q      <= ~tog_q;
      erase_done <= 1'b0;
      if (erase_req && !erase_done)
      begin
        erase_done <= (cnt_q == delay);
        cnt_q      <= (cnt_q == delay) ? 8'h00 : cnt_q + 8'h01;
      end
    end
  end
endmodule

// ### tb_top.sv
// self-checking bench for the flash erase, security and margin sequencer
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import fesm_pkg::*;
  logic             clock, reset_n, cmd_word_wr, cmd_launch;
  logic             access_error_clear, protection_violation_clear;
  logic [2:0]       command_word_index;
  logic [15:0]      cmd_word_wr_data;
  logic [4:0]       cmd_enable_mask;
  logic [1:0]       backdoor_key_enable_field, erase_block;
  logic [63:0]      stored_key_words;
  logic             target_block_protected, target_sector_protected;
  logic             pflash_protected_any, dflash_protected_any;
  logic             erase_done, erase_verify_error, erase_verify_uncorrectable;
  logic             command_complete_flag, access_error_flag, protection_violation_flag;
  logic             verify_error_flag, verify_uncorrectable_flag, security_released;
  logic             backdoor_locked, erase_req, fail_v, fail_u, prot_sec;
  fesm_erase_kind_t erase_kind;
  logic [15:0]      erase_addr;
  fesm_margin_t     pflash_read_margin, dflash_read_margin;
  logic [3:0]       prot_blk;
  logic [15:0]      wd [5];
  int               n_mismatch, n_tests, wait_n;
  // table rows: word0, word1, last index; all must end in an access error
  logic [34:0] etbl [12] = '{{16'h0903, 16'h0000, 3'h0}, {16'h0901, 16'h0000, 3'h1},
    {16'h0903, 16'h0004, 3'h1}, {16'h0900, 16'h0001, 3'h1}, {16'h0A03, 16'h0004, 3'h1},
    {16'h0A00, 16'h0000, 3'h1}, {16'h0B00, 16'h0000, 3'h1}, {16'h0C00, 16'h1111, 3'h3},
    {16'h0D03, 16'h0003, 3'h1}, {16'h0D03, 16'h0001, 3'h0}, {16'h0D02, 16'h0001, 3'h1},
    {16'h0500, 16'h0000, 3'h0}};
  // one valid launch per command, in availability-mask bit order
  logic [34:0] vtbl [5] = '{{16'h0903, 16'h0000, 3'h1}, {16'h0A03, 16'h0000, 3'h1},
    {16'h0B00, 16'h0000, 3'h0}, {16'h0C00, 16'h1111, 3'h4}, {16'h0D03, 16'h0000, 3'h1}};

  fesm_seq fesm_seq_i (.clock, .reset_n, .cmd_word_wr, .command_word_index, .cmd_word_wr_data,
    .cmd_launch, .access_error_clear, .protection_violation_clear, .cmd_enable_mask,
    .backdoor_key_enable_field, .stored_key_words, .target_block_protected,
    .target_sector_protected, .pflash_protected_any, .dflash_protected_any, .erase_done,
    .erase_verify_error, .erase_verify_uncorrectable, .command_complete_flag,
    .access_error_flag, .protection_violation_flag, .verify_error_flag,
    .verify_uncorrectable_flag, .security_released, .backdoor_locked, .erase_req,
    .erase_kind, .erase_block, .erase_addr, .pflash_read_margin, .dflash_read_margin);

  fesm_array_model fesm_array_model_i (.clock, .reset_n, .erase_req, .erase_block,
    .delay(8'h14), .fail_verify(fail_v), .fail_ecc(fail_u), .prot_blk,
    .prot_sector(prot_sec), .erase_done, .erase_verify_error,
    .erase_verify_uncorrectable, .target_block_protected, .target_sector_protected,
    .pflash_protected_any, .dflash_protected_any);

  // ==========================================
  // clock, 25 ns period
  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("comparisons=%0d mismatches=%0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic do_reset();
    reset_n <= 1'b0;
    repeat (4) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
  endtask

  // ==========================================
  // write words 0..last, launch, wait for completion; nothing is written while busy
  task automatic cmd(input logic [15:0] w0, input logic [15:0] w1, input logic [2:0] last);
    wd[0] = w0;
    wd[1] = w1;
    for (int i = 0; i <= last; i++)
    begin
      @(posedge clock);
      cmd_word_wr                <= 1'b1;
      command_word_index         <= i[2:0];
      cmd_word_wr_data           <= wd[i];
      access_error_clear         <= (i == 0);
      protection_violation_clear <= (i == 0);
    end
    @(posedge clock);
    cmd_word_wr                <= 1'b0;
    access_error_clear         <= 1'b0;
    protection_violation_clear <= 1'b0;
    cmd_launch                 <= 1'b1;
    @(posedge clock);
    cmd_launch <= 1'b0;
    // look a little after the edge so the flop outputs have settled
    #1;
    chk(command_complete_flag, 1'b0);
    for (wait_n = 0; wait_n < 300 && command_complete_flag !== 1'b1; wait_n++)
    begin
      @(posedge clock);
      #1;
    end
    #1;
    chk(command_complete_flag, 1'b1);
  endtask

  task automatic flags(input logic [3:0] e);
    chk({access_error_flag, protection_violation_flag, verify_error_flag, verify_uncorrectable_flag}, e);
  endtask

  // ==========================================
  // main sequence
  initial
  begin
    {reset_n, cmd_word_wr, cmd_launch, access_error_clear, protection_violation_clear} = 5'h00;
    {command_word_index, cmd_word_wr_data, fail_v, fail_u, prot_sec, prot_blk} = 26'h0;
    cmd_enable_mask = 5'h1F;
    backdoor_key_enable_field = 2'h2;
    stored_key_words = 64'h4444_3333_2222_1111;
    wd[2] = 16'h2222;
    wd[3] = 16'h3333;
    wd[4] = 16'h4444;
    do_reset();
    chk({command_complete_flag, access_error_flag, security_released, backdoor_locked, erase_req}, 5'h10);
    chk({pflash_read_margin, dflash_read_margin}, 4'h0);
    $display("test reset done");
    cmd(16'h0903, 16'h0010, 3'h1);
    flags(4'h0);
    chk({erase_kind, erase_block, erase_addr}, {FESM_ER_BLOCK, 2'h3, 16'h0010});
    chk(wait_n >= 20, 1'b1);
    cmd(16'h0900, 16'h0002, 3'h1);
    flags(4'h0);
    {fail_v, fail_u} = 2'b11;
    cmd(16'h0A03, 16'h0208, 3'h1);
    flags(4'h3);
    chk({erase_kind, erase_addr}, {FESM_ER_SECTOR, 16'h0208});
    $display("test erase done");
    {fail_v, fail_u} = 2'b00;
    foreach (etbl[i])
    begin
      cmd(etbl[i][34:19], etbl[i][18:3], etbl[i][2:0]);
      flags(4'h8);
    end
    for (int b = 0; b < 5; b++)
    begin
      cmd_enable_mask <= ~(5'h01 << b);
      cmd(vtbl[b][34:19], vtbl[b][18:3], vtbl[b][2:0]);
      flags(4'h8);
    end
    cmd_enable_mask <= 5'h1F;
    $display("test access errors done");
    prot_blk = 4'h8;
    cmd(16'h0903, 16'h0000, 3'h1);
    flags(4'h4);
    prot_blk = 4'h1;
    cmd(16'h0B00, 16'h0000, 3'h0);
    flags(4'h4);
    prot_blk = 4'h0;
    prot_sec = 1'b1;
    cmd(16'h0A03, 16'h0000, 3'h1);
    flags(4'h4);
    prot_sec = 1'b0;
    $display("test protection done");
    fail_v = 1'b1;
    cmd(16'h0B00, 16'h0000, 3'h0);
    flags(4'h2);
    chk(security_released, 1'b0);
    fail_v = 1'b0;
    cmd(16'h0B00, 16'h0000, 3'h0);
    flags(4'h0);
    chk({erase_kind, security_released}, {FESM_ER_ALL, 1'b1});
    $display("test unsecure done");
    do_reset();
    backdoor_key_enable_field <= 2'h1;
    cmd(16'h0C00, 16'h1111, 3'h4);
    flags(4'h8);
    backdoor_key_enable_field <= 2'h2;
    chk(security_released, 1'b0);
    // key commands come from the bench, never from code in the key block
    cmd(16'h0C00, 16'h1111, 3'h4);
    chk({access_error_flag, security_released}, 2'b01);
    do_reset();
    wd[4] = 16'h4445;
    cmd(16'h0C00, 16'h1111, 3'h4);
    chk({access_error_flag, security_released, backdoor_locked}, 3'b101);
    wd[4] = 16'h4444;
    cmd(16'h0C00, 16'h1111, 3'h4);
    chk({access_error_flag, security_released}, 2'b10);
    do_reset();
    chk(backdoor_locked, 1'b0);
    $display("test key done");
    cmd(16'h0D03, 16'h0001, 3'h1);
    chk({pflash_read_margin, dflash_read_margin}, {FESM_MG_ERASED, FESM_MG_ERASED});
    cmd(16'h0D00, 16'h0002, 3'h1);
    chk({pflash_read_margin, dflash_read_margin}, {FESM_MG_ERASED, FESM_MG_PROGRAMMED});
    cmd(16'h0D03, 16'h0000, 3'h1);
    chk({pflash_read_margin, dflash_read_margin}, {FESM_MG_NORMAL, FESM_MG_NORMAL});
    flags(4'h0);
    $display("test margin done");
    conclude();
  end

  // ==========================================
  // watchdog: the full run needs a few hundred cycles
  initial
  begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    conclude();
  end
endmodule
